// ---- tb/sbs_ctl_model.sv ----
// controller-side model that drives the sram port bus
`timescale 1ns/1ps
`default_nettype none
module sbs_ctl_model (
  // clock
  input wire logic clk_in,
  // bus towards the port
  output logic [3:0] addr_out,
  output logic rnw_out,
  output logic adv_out,
  output logic cs_a_n_out,
  output logic cs_b_n_out,
  output logic cs_c_out,
  output logic hold_out,
  output logic [1:0] bw_out,
  output logic [17:0] dq_out
);
  initial begin
    {addr_out, rnw_out, adv_out, cs_a_n_out, cs_b_n_out, cs_c_out, hold_out} = 10'h03c;
    {bw_out, dq_out} = 20'h30000;
  end
  // one bus cycle: drive at falling edge, hold through the rising edge
  task automatic cyc(input logic ld, rw, sel, hd, input logic [3:0] ad, input logic [1:0] b,
                     input logic [17:0] d, input logic dv);
    @(negedge clk_in);
    adv_out <= ~ld;
    rnw_out <= rw;
    addr_out <= ad;
    hold_out <= hd;
    bw_out <= b;
    cs_a_n_out <= ~sel;
    cs_b_n_out <= ~sel;
    cs_c_out <= sel;
    dq_out <= dv ? d : ~dq_out;
    @(posedge clk_in);
    #1;
  endtask : cyc
endmodule : sbs_ctl_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the synchronous burst sram port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic H = 1'h1;
  localparam logic L = 1'h0;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic oe_n = 1'h0;
  logic burst_order_sel = 1'h0;
  logic [3:0] a;
  logic rnw, adv, cs_a_n, cs_b_n, cs_c, hold, oe;
  logic [1:0] bw_n;
  logic [17:0] di, dq, mem [16];
  int errors = 0;
  int n_compared = 0;
  always #2 clk = ~clk;
  sbs_ctl_model u_ctl (.clk_in(clk), .addr_out(a), .rnw_out(rnw), .adv_out(adv),
    .cs_a_n_out(cs_a_n), .cs_b_n_out(cs_b_n), .cs_c_out(cs_c), .hold_out(hold),
    .bw_out(bw_n), .dq_out(di));
  sbs_port #(.ADDR_W(4)) u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(a),
    .READ_NOT_WRITE_IN(rnw), .ADVANCE_NOT_LOAD_IN(adv), .CHIP_SELECT_A_N_IN(cs_a_n),
    .CHIP_SELECT_B_N_IN(cs_b_n), .CHIP_SELECT_C_HIGH_IN(cs_c), .CLOCK_HOLD_IN(hold),
    .BYTE_WRITE_N_IN(bw_n), .BURST_ORDER_SEL_IN(burst_order_sel), .OUTPUT_ENABLE_N_IN(oe_n),
    .DQ_IN(di), .DQ_OUT(dq), .DQ_OE_OUT(oe));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [3:0] ba(input logic [3:0] s, input int k);
    return {s[3:2], burst_order_sel ? s[1:0] ^ 2'(k) : s[1:0] + 2'(k)};
  endfunction : ba
  // read cycle: loads read, advances carry write direction which must be ignored
  task automatic rx(input logic ld, input logic [3:0] ad, input logic [3:0] e);
    u_ctl.cyc(ld, ld, H, L, ad, 2'h3, 18'h0, L);
    chk(dq, mem[e]);
    chk(18'(oe), 18'h1);
  endtask : rx
  task automatic t_write;
    logic [3:0] wa;
    u_ctl.cyc(H, L, H, L, 4'h8, 2'h0, 18'h0, L);
    for (int i = 0; i < 8; i++) begin
      wa = i < 4 ? 4'h8 + 4'(i) : {2'h1, 2'(i + 2)};
      mem[wa] = 18'h100 + 18'(i);
      u_ctl.cyc(i % 4 == 3, L, H, L, i < 4 ? 4'h6 : 4'h9, {i == 7, L}, mem[wa], H);
      chk(18'(oe), 18'h0);
    end
    $display("t_write done");
  endtask : t_write
  task automatic t_read;
    rx(H, 4'h9, 4'h9);
    for (int k = 1; k < 5; k++) rx(L, 4'h0, ba(4'h9, k));
    rx(H, 4'h6, 4'h6);
    @(negedge clk) oe_n = H;
    #1 chk(18'(oe), 18'h0);
    @(negedge clk) oe_n = L;
    repeat (2) u_ctl.cyc(H, L, L, H, 4'h0, 2'h3, 18'h0, L);
    chk(dq, mem[6]);
    rx(L, 4'h0, 4'h7);
    u_ctl.cyc(H, H, L, L, 4'h0, 2'h3, 18'h0, L);
    chk(18'(oe), 18'h0);
    $display("t_read done");
  endtask : t_read
  task automatic t_hold_wr;
    mem[12] = 18'h2aaaa;
    mem[13] = 18'h15555;
    u_ctl.cyc(H, L, H, L, 4'hc, 2'h0, 18'h0, L);
    repeat (2) u_ctl.cyc(H, H, L, H, 4'h0, 2'h3, 18'h0, L);
    u_ctl.cyc(H, L, H, L, 4'hd, 2'h0, mem[12], H);
    u_ctl.cyc(H, H, L, H, 4'h0, 2'h3, 18'h0, L);
    u_ctl.cyc(H, H, H, L, 4'hc, 2'h3, mem[13], H);
    chk(dq, mem[12]);
    rx(H, 4'hd, 4'hd);
    u_ctl.cyc(H, H, L, L, 4'h0, 2'h3, 18'h0, L);
    $display("t_hold_wr done");
  endtask : t_hold_wr
  // upper lane only written while the same word is read back, then a write with no lanes
  task automatic t_lanes;
    mem[4][17:9] = 9'h1ff;
    u_ctl.cyc(H, L, H, L, 4'h4, 2'h1, 18'h0, L);
    u_ctl.cyc(H, H, H, L, 4'h4, 2'h3, 18'h3ffff, H);
    chk(dq, mem[4]);
    u_ctl.cyc(H, L, H, L, 4'h5, 2'h3, 18'h0, L);
    u_ctl.cyc(H, H, L, L, 4'h0, 2'h3, 18'h3ffff, H);
    rx(H, 4'h5, 4'h5);
    u_ctl.cyc(H, H, L, L, 4'h0, 2'h3, 18'h0, L);
    $display("t_lanes done");
  endtask : t_lanes
  task automatic t_order;
    @(negedge clk) burst_order_sel = H;
    repeat (3) u_ctl.cyc(H, H, L, L, 4'h0, 2'h3, 18'h0, L);
    rx(H, 4'h9, 4'h9);
    for (int k = 1; k < 4; k++) rx(L, 4'h0, ba(4'h9, k));
    $display("t_order done");
  endtask : t_order
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = L;
    t_write();
    u_ctl.cyc(H, L, L, L, 4'h0, 2'h3, 18'h3ffff, H);
    mem[9][8:0] = 9'h1ff;
    t_read();
    t_hold_wr();
    t_lanes();
    t_order();
    end_of_test();
  end
  initial begin
    #4000;
    errors++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// ---- verilog/sbs_pkg.sv ----
// types of the synchronous burst sram port
`default_nettype none
package sbs_pkg;
  `include "sbs_regs.svh"

  typedef enum logic [1:0] {
    SBS_PH_IDLE = 2'b00,
    SBS_PH_READ = 2'b01,
    SBS_PH_WRITE = 2'b10
  } sbs_phase_t;

  // transfer whose data phase falls in the current cycle
  typedef struct packed {
    sbs_phase_t phase;
    logic [`SBS_LANES-1:0] bw_n;
  } sbs_pend_t;

  // burst position: start offset and step count
  typedef struct packed {
    logic [`SBS_BURST_W-1:0] base;
    logic [`SBS_BURST_W-1:0] cnt;
  } sbs_burst_t;
endpackage : sbs_pkg
`default_nettype wire

// ---- verilog/sbs_port.sv ----
// synchronous burst sram port with flow-through read data
// Notes on behaviour
// RL1: read loaded at n drives word in n+1
// RL2: advance edges step counter, output next word
// RL3: back-to-back read loads, no idle cycle
// RL4: controller drives write data one enabled cycle later
// RL5: burst write stores each word at next address
// RL6: new write load accepted with last data
// RL7: clock hold freezes DQ_OUT and all state but the burst order strap flops
// RL8: held edge after write load delays data phase
// RL9: several held edges, then one write per cycle
// RL10: second low chip select times like first
// RL11: high chip select times like lows, inverted
// RL12: linear or interleaved order, wraps after four
// RL13: direction fixed at load, ignored on advance
// RL14: deselecting load ends transfers, bus floats after
// RL15: two byte enables gate lower and upper lanes
// RL16: bus floats when output disabled or writing
`timescale 1ns/1ps
`default_nettype none
`include "sbs_regs.svh"

module sbs_port
  import sbs_pkg::*;
#(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int LANE_W = `SBS_LANE_W,
  parameter int LANES = `SBS_LANES
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // address and control
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic READ_NOT_WRITE_IN,
  input wire logic ADVANCE_NOT_LOAD_IN,
  input wire logic CHIP_SELECT_A_N_IN,
  input wire logic CHIP_SELECT_B_N_IN,
  input wire logic CHIP_SELECT_C_HIGH_IN,
  input wire logic CLOCK_HOLD_IN,
  input wire logic [LANES-1:0] BYTE_WRITE_N_IN,
  input wire logic BURST_ORDER_SEL_IN,
  input wire logic OUTPUT_ENABLE_N_IN,
  // data bus
  input wire logic [LANES*LANE_W-1:0] DQ_IN,
  output logic [LANES*LANE_W-1:0] DQ_OUT,
  output logic DQ_OE_OUT
);

  localparam int DQ_W = LANES * LANE_W;

  logic [DQ_W-1:0] mem [0:(1<<ADDR_W)-1];
  sbs_pend_t pend;
  sbs_burst_t burst;
  logic [ADDR_W-1:0] q_addr;
  logic [DQ_W-1:0] dq_q;
  logic order_meta;
  logic order_sync;

  logic selected;
  logic enabled;
  logic load;
  logic step;
  logic wr_now;
  logic [DQ_W-1:0] merged;
  logic [`SBS_BURST_W-1:0] next_cnt;
  logic [`SBS_BURST_W-1:0] next_low;
  logic [ADDR_W-1:0] next_addr;
  sbs_pend_t next_pend;

  // burst order strap through two flip-flops
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      order_meta <= `SBS_SYNC_RST;
      order_sync <= `SBS_SYNC_RST;
    end else begin
      order_meta <= BURST_ORDER_SEL_IN;
      order_sync <= order_meta;
    end
  end

  // decode of the sampled control
  always_comb begin
    selected = !CHIP_SELECT_A_N_IN && !CHIP_SELECT_B_N_IN && CHIP_SELECT_C_HIGH_IN;
    enabled = !CLOCK_HOLD_IN; // RL7
    load = enabled && !ADVANCE_NOT_LOAD_IN;
    step = enabled && ADVANCE_NOT_LOAD_IN && (pend.phase != SBS_PH_IDLE); // RL2
    wr_now = enabled && (pend.phase == SBS_PH_WRITE); // RL4 RL8 RL9
  end

  // burst address sequence
  always_comb begin
    next_cnt = burst.cnt + `SBS_CNT_STEP;
    if (order_sync) begin
      next_low = burst.base ^ next_cnt; // RL12
    end else begin
      next_low = burst.base + next_cnt; // RL12
    end
    if (load) begin
      next_addr = ADDR_IN;
    end else begin
      next_addr = {q_addr[ADDR_W-1:`SBS_BURST_W], next_low}; // RL2 RL5
    end
  end

  // operation that owns the next data phase
  always_comb begin
    next_pend = pend;
    if (load) begin
      if (!selected) begin
        next_pend.phase = SBS_PH_IDLE; // RL14
        next_pend.bw_n = `SBS_BW_NONE;
      end else if (READ_NOT_WRITE_IN) begin
        next_pend.phase = SBS_PH_READ;
        next_pend.bw_n = `SBS_BW_NONE;
      end else begin
        next_pend.phase = SBS_PH_WRITE;
        next_pend.bw_n = BYTE_WRITE_N_IN; // RL15
      end
    end else if (step && pend.phase == SBS_PH_WRITE) begin
      next_pend.bw_n = BYTE_WRITE_N_IN; // RL5
    end
  end

  // write word with untouched lanes kept
  always_comb begin
    merged = mem[q_addr];
    for (int i = 0; i < LANES; i++) begin
      if (!pend.bw_n[i]) begin
        merged[i*LANE_W +: LANE_W] = DQ_IN[i*LANE_W +: LANE_W]; // RL15
      end
    end
  end

  // array write in the data phase
  always_ff @(posedge CLK_SYS_IN) begin
    if (wr_now) begin
      mem[q_addr] <= merged; // RL4 RL5 RL6
    end
  end

  // pending operation and burst position
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pend.phase <= SBS_PH_IDLE;
      pend.bw_n <= `SBS_BW_NONE;
      burst.base <= `SBS_CNT_RST;
      burst.cnt <= `SBS_CNT_RST;
      q_addr <= '0;
    end else if (enabled) begin // RL7
      pend <= next_pend; // RL13
      if (load) begin
        burst.base <= ADDR_IN[`SBS_BURST_W-1:0];
        burst.cnt <= `SBS_CNT_RST;
        q_addr <= ADDR_IN; // RL3 RL6
      end else if (step) begin
        burst.cnt <= next_cnt; // RL12
        q_addr <= next_addr;
      end
    end
  end

  // read word captured at the control edge, forwarded from a same-edge write
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dq_q <= `SBS_DQ_RST;
    end else if (enabled && next_pend.phase == SBS_PH_READ) begin
      if (wr_now && next_addr == q_addr) begin
        dq_q <= merged;
      end else begin
        dq_q <= mem[next_addr]; // RL1 RL2 RL3
      end
    end
  end

  // bus drive, gated asynchronously by the output enable
  always_comb begin
    DQ_OUT = dq_q;
    DQ_OE_OUT = (pend.phase == SBS_PH_READ) && !OUTPUT_ENABLE_N_IN; // RL1 RL14 RL16
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  a_read_latency: assert property ( // RL1
    load && selected && READ_NOT_WRITE_IN |=>
      pend.phase == SBS_PH_READ && dq_q == mem[q_addr] && q_addr == $past(ADDR_IN))
    else $error("read load not output next cycle");

  a_burst_step: assert property ( // RL2
    step |=> burst.cnt == $past(next_cnt) && q_addr[`SBS_BURST_W-1:0] == $past(next_low))
    else $error("burst counter did not step");

  a_read_stream: assert property ( // RL3
    pend.phase == SBS_PH_READ && load && selected && READ_NOT_WRITE_IN
      ##1 !CLOCK_HOLD_IN |-> pend.phase == SBS_PH_READ && DQ_OE_OUT == !OUTPUT_ENABLE_N_IN)
    else $error("idle cycle between back-to-back reads");

  a_write_store: assert property ( // RL4
    wr_now && !pend.bw_n[0] |=> mem[$past(q_addr)][LANE_W-1:0] == $past(DQ_IN[LANE_W-1:0]))
    else $error("lower lane not written");

  a_burst_write: assert property ( // RL5
    step && pend.phase == SBS_PH_WRITE |=> pend.phase == SBS_PH_WRITE
      && q_addr[`SBS_BURST_W-1:0] == $past(next_low))
    else $error("burst write address not advanced");

  a_write_chain: assert property ( // RL6
    wr_now && load && selected && !READ_NOT_WRITE_IN |=>
      pend.phase == SBS_PH_WRITE && q_addr == $past(ADDR_IN))
    else $error("chained write load lost");

  a_hold_keep: assert property ( // RL7
    CLOCK_HOLD_IN |=> $stable(dq_q) && $stable(pend) && $stable(q_addr) && $stable(burst))
    else $error("state changed on a held edge");

  a_held_write: assert property ( // RL8
    pend.phase == SBS_PH_WRITE && CLOCK_HOLD_IN [*2] |=> pend.phase == SBS_PH_WRITE)
    else $error("write data phase lost while held");

  a_wrap: assert property ( // RL12
    step && burst.cnt == `SBS_CNT_LAST |=> q_addr[`SBS_BURST_W-1:0] == burst.base)
    else $error("burst did not wrap to start");

  a_dir_kept: assert property ( // RL13
    step |=> pend.phase == $past(pend.phase))
    else $error("burst direction changed on advance");

  a_deselect: assert property ( // RL14
    load && !selected |=> pend.phase == SBS_PH_IDLE && !DQ_OE_OUT)
    else $error("bus driven after deselect");

  a_no_lane: assert property ( // RL15
    wr_now && pend.bw_n == `SBS_BW_NONE |=> mem[$past(q_addr)] == $past(mem[q_addr]))
    else $error("word changed with no byte enable");

  a_float: assert property ( // RL16
    OUTPUT_ENABLE_N_IN || pend.phase != SBS_PH_READ |-> !DQ_OE_OUT)
    else $error("bus driven while disabled or writing");

  c_burst_read: cover property (load && selected && READ_NOT_WRITE_IN ##1 step [*3]);
  c_burst_write: cover property (load && selected && !READ_NOT_WRITE_IN ##1 step [*3]);
  c_held_read: cover property (pend.phase == SBS_PH_READ && CLOCK_HOLD_IN [*2] ##1 load);
  c_write_read: cover property (wr_now && load && selected && READ_NOT_WRITE_IN);

endmodule : sbs_port
`default_nettype wire

// ---- verilog/sbs_regs.svh ----
// constants of the synchronous burst sram port
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

`define SBS_ADDR_W 20
`define SBS_LANE_W 9
`define SBS_LANES 2
`define SBS_DQ_W 18
`define SBS_BURST_W 2

`define SBS_CNT_RST 2'h0
`define SBS_CNT_STEP 2'h1
`define SBS_CNT_LAST 2'h3
`define SBS_BW_NONE 2'h3
`define SBS_DQ_RST 18'h00000
`define SBS_SYNC_RST 1'h0

`endif
